// [logic/fxq_core.sv]
// Fixed-point convert unit: register port, operand alignment, quantize and overflow stages, stored result.
//
// Notes on behaviour
// - Binary points of both operands are aligned before add or subtract.
// - Too many integer bits: the chosen overflow mode gives the stored value.
// - Too many fraction bits: the chosen quantization mode drops them.
// - Values are signed or unsigned vectors with a set fraction width.
// - Round half up: nearest value, ties go toward plus infinity.
// - Round half toward zero: nearest value, ties go toward zero.
// - Round half down: nearest value, ties go toward minus infinity.
// - Round half away: ties move away from zero.
// - Round half even: nearest value, ties leave the kept low bit zero.
// - A tie is first dropped bit one and all lower dropped bits zero.
// - Truncate floor: drop bits, result moves toward minus infinity.
// - Truncate toward zero: floor for positives, negatives move toward zero.
// - Clamp to limits: overflow gives the largest or most negative value.
// - Clamp to zero: any overflow stores zero.
// - Clamp symmetric: positive gives max, negative gives minus max or zero.
// - Modular wrap, no saturated bits: high bits outside the range are dropped.
// - Modular wrap with a saturated bit count forces that many top bits to one.
// - Modular wrap with saturated bits keeps the original sign bit.
// - Sign-magnitude wrap: new sign is the lowest dropped bit.
// - Sign-magnitude wrap inverts the remaining bits when the sign changes.
// - Sign-magnitude wrap with saturated bits sets top bits, keeps the sign.
// - Default quantization mode is truncate floor.
// - Default overflow mode is modular wrap with zero saturated bits.
// - Quantize and overflow act only when the result is stored.
`timescale 1ns/1ns
module fxq_core #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Stored result
   output logic [W-1:0] result,
   output logic done
);

   localparam int XW = 2 * W + 2;

   fxq_pkg::fxq_qmode_e qmode_q;
   fxq_pkg::fxq_omode_e omode_q;
   fxq_pkg::fxq_op_e op_q;
   logic [4:0] nsat_q;
   logic dsign_q;
   logic asign_q;
   logic bsign_q;
   logic [4:0] fa_q;
   logic [4:0] fb_q;
   logic [4:0] fd_q;
   logic [W-1:0] opa_q;
   logic [W-1:0] opb_q;
   logic go_q;
   logic [W-1:0] result_q;
   logic done_q;
   logic povf_q;
   logic novf_q;
   logic inexact_q;
   logic [31:0] rdata_q;
   logic [XW-1:0] a_w;
   logic [XW-1:0] b_w;
   logic [XW-1:0] x_w;
   logic [4:0] r_w;
   logic [XW-1:0] q_w;
   logic q_inc;
   logic q_tie;
   logic q_inexact;
   logic [W-1:0] y_w;
   logic povf_w;
   logic novf_w;

   // Limit a fraction count to the operand width.
   function automatic logic [4:0] clamp_frac(input logic [4:0] f);
      return (f > 5'(W)) ? 5'(W) : f;
   endfunction

   // Extend an operand and shift it so that its binary point sits W bits up in the wide format.
   function automatic logic [XW-1:0] align(input logic [W-1:0] v, input logic sgn, input logic [4:0] f);
      logic [XW-1:0] ext;
      ext = {{(XW-W){sgn & v[W-1]}}, v};
      return ext << (5'(W) - clamp_frac(f));
   endfunction

   // Mode and format configuration, written through the control register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         qmode_q <= fxq_pkg::QMODE_RESET;
         omode_q <= fxq_pkg::OMODE_RESET;
         nsat_q <= fxq_pkg::NSAT_RESET;
         op_q <= fxq_pkg::OP_RESET;
         dsign_q <= 1'b1;
         asign_q <= 1'b1;
         bsign_q <= 1'b1;
      end else if (wr && addr == fxq_pkg::ADDR_CTRL) begin
         qmode_q <= fxq_pkg::fxq_qmode_e'(wdata[fxq_pkg::QMODE_LSB +: fxq_pkg::MODE_BITS]);
         omode_q <= fxq_pkg::fxq_omode_e'(wdata[fxq_pkg::OMODE_LSB +: fxq_pkg::MODE_BITS]);
         nsat_q <= wdata[fxq_pkg::NSAT_LSB +: fxq_pkg::FRAC_BITS];
         op_q <= fxq_pkg::fxq_op_e'(wdata[fxq_pkg::OP_LSB +: fxq_pkg::OP_BITS]);
         dsign_q <= wdata[fxq_pkg::DSIGN_BIT];
         asign_q <= wdata[fxq_pkg::ASIGN_BIT];
         bsign_q <= wdata[fxq_pkg::BSIGN_BIT];
      end
   end

   // Fraction widths of the two sources and the destination.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fa_q <= fxq_pkg::FRAC_RESET;
         fb_q <= fxq_pkg::FRAC_RESET;
         fd_q <= fxq_pkg::FRAC_RESET;
      end else if (wr && addr == fxq_pkg::ADDR_FRAC) begin
         fa_q <= wdata[fxq_pkg::FA_LSB +: fxq_pkg::FRAC_BITS];
         fb_q <= wdata[fxq_pkg::FB_LSB +: fxq_pkg::FRAC_BITS];
         fd_q <= wdata[fxq_pkg::FD_LSB +: fxq_pkg::FRAC_BITS];
      end
   end

   // Operand registers.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         opa_q <= {W{1'b0}};
         opb_q <= {W{1'b0}};
      end else begin
         if (wr && addr == fxq_pkg::ADDR_OPA) begin
            opa_q <= wdata[W-1:0];
         end
         if (wr && addr == fxq_pkg::ADDR_OPB) begin
            opb_q <= wdata[W-1:0];
         end
      end
   end

   // A command write launches one conversion in the following cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         go_q <= 1'b0;
      end else begin
         go_q <= wr && addr == fxq_pkg::ADDR_CMD;
      end
   end

   // Full-precision arithmetic; the wide format has room for any sum, so nothing is lost here.
   always_comb begin
      a_w = align(opa_q, asign_q, fa_q);
      b_w = align(opb_q, bsign_q, fb_q);
      case (op_q)
         fxq_pkg::fxq_op_add: x_w = a_w + b_w;
         fxq_pkg::fxq_op_sub: x_w = a_w - b_w;
         fxq_pkg::fxq_op_pass: x_w = a_w;
         default: x_w = a_w;
      endcase
      r_w = 5'(W) - clamp_frac(fd_q);
   end

   // Low-order bits are settled first.
   fxq_quant #(
      .W(W),
      .XW(XW)
   ) u_quant (
      .x(x_w),
      .r(r_w),
      .qmode(qmode_q),
      .q(q_w),
      .inc(q_inc),
      .tie(q_tie),
      .inexact(q_inexact)
   );

   // The rounded value feeds the range check, so a rounding carry out of range is caught.
   fxq_ovf #(
      .W(W),
      .XW(XW)
   ) u_ovf (
      .q(q_w),
      .omode(omode_q),
      .nsat(nsat_q),
      .dsign(dsign_q),
      .y(y_w),
      .pos_ovf(povf_w),
      .neg_ovf(novf_w)
   );

   // The fitted value is stored only on a launch; intermediate sums are never rounded.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result_q <= {W{1'b0}};
         povf_q <= 1'b0;
         novf_q <= 1'b0;
         inexact_q <= 1'b0;
      end else if (go_q) begin
         result_q <= y_w;
         povf_q <= povf_w;
         novf_q <= novf_w;
         inexact_q <= q_inexact;
      end
   end

   // Done is sticky; a launch completing in the cycle of a status read wins over the clear.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_q <= 1'b0;
      end else if (go_q) begin
         done_q <= 1'b1;
      end else if (rd && addr == fxq_pkg::ADDR_STATUS) begin
         done_q <= 1'b0;
      end
   end

   // Read data for the cycle after the strobe; unmapped and write-only addresses read zero.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            fxq_pkg::ADDR_CTRL: begin
               rdata_q <= 32'h0000_0000;
               rdata_q[fxq_pkg::QMODE_LSB +: fxq_pkg::MODE_BITS] <= qmode_q;
               rdata_q[fxq_pkg::OMODE_LSB +: fxq_pkg::MODE_BITS] <= omode_q;
               rdata_q[fxq_pkg::NSAT_LSB +: fxq_pkg::FRAC_BITS] <= nsat_q;
               rdata_q[fxq_pkg::DSIGN_BIT] <= dsign_q;
               rdata_q[fxq_pkg::ASIGN_BIT] <= asign_q;
               rdata_q[fxq_pkg::BSIGN_BIT] <= bsign_q;
               rdata_q[fxq_pkg::OP_LSB +: fxq_pkg::OP_BITS] <= op_q;
            end
            fxq_pkg::ADDR_FRAC: begin
               rdata_q <= 32'h0000_0000;
               rdata_q[fxq_pkg::FA_LSB +: fxq_pkg::FRAC_BITS] <= fa_q;
               rdata_q[fxq_pkg::FB_LSB +: fxq_pkg::FRAC_BITS] <= fb_q;
               rdata_q[fxq_pkg::FD_LSB +: fxq_pkg::FRAC_BITS] <= fd_q;
            end
            fxq_pkg::ADDR_OPA: rdata_q <= {{(32-W){1'b0}}, opa_q};
            fxq_pkg::ADDR_OPB: rdata_q <= {{(32-W){1'b0}}, opb_q};
            fxq_pkg::ADDR_RESULT: rdata_q <= {{(32-W){1'b0}}, result_q};
            fxq_pkg::ADDR_STATUS: begin
               rdata_q <= 32'h0000_0000;
               rdata_q[fxq_pkg::DONE_BIT] <= done_q;
               rdata_q[fxq_pkg::POVF_BIT] <= povf_q;
               rdata_q[fxq_pkg::NOVF_BIT] <= novf_q;
               rdata_q[fxq_pkg::INEXACT_BIT] <= inexact_q;
            end
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // Outputs come straight from their flip-flops.
   assign rdata = rdata_q;
   assign result = result_q;
   assign done = done_q;

   // Checks on the datapath, sampled on the clock while out of reset.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence launch_s;
      wr && addr == fxq_pkg::ADDR_CMD;
   endsequence

   sequence store_s;
      ##2 (done_q && result_q == $past(y_w));
   endsequence

   store_timing_a:
      assert property (launch_s |-> store_s)
      else $error("result not stored two edges after command write");

   result_hold_a:
      assert property (!go_q |=> $stable(result_q))
      else $error("result changed without a launch");

   tie_detect_a:
      assert property (q_tie == ((r_w != 5'h00) && x_w[r_w - 5'h01]
                       && ((x_w & ~({XW{1'b1}} << (r_w - 5'h01))) == {XW{1'b0}})))
      else $error("tie flag disagrees with dropped bits");

   half_up_a:
      assert property ((qmode_q == fxq_pkg::fxq_round_half_up && q_tie) |-> q_inc)
      else $error("half up tie not rounded up");

   half_zero_a:
      assert property ((qmode_q == fxq_pkg::fxq_round_half_toward_zero && q_tie) |-> q_inc == x_w[XW-1])
      else $error("half toward zero tie went the wrong way");

   half_down_a:
      assert property ((qmode_q == fxq_pkg::fxq_round_half_down && q_tie) |-> !q_inc)
      else $error("half down tie rounded up");

   half_even_a:
      assert property ((qmode_q == fxq_pkg::fxq_round_half_even && q_tie) |-> !q_w[0])
      else $error("half even tie left odd low bit");

   floor_trunc_a:
      assert property (qmode_q == fxq_pkg::fxq_truncate_floor |-> !q_inc && q_w == XW'($signed(x_w) >>> r_w))
      else $error("floor truncation did not shift down");

   zero_trunc_a:
      assert property ((qmode_q == fxq_pkg::fxq_truncate_toward_zero && !x_w[XW-1]) |-> !q_inc)
      else $error("toward zero truncation rounded a positive value up");

   clamp_limits_a:
      assert property ((omode_q == fxq_pkg::fxq_clamp_to_limits && novf_w) |->
                       y_w == (dsign_q ? {1'b1, {(W-1){1'b0}}} : {W{1'b0}}))
      else $error("negative clamp gave wrong limit");

   clamp_zero_a:
      assert property ((omode_q == fxq_pkg::fxq_clamp_to_zero && (povf_w || novf_w)) |-> y_w == {W{1'b0}})
      else $error("clamp to zero gave nonzero result");

   clamp_sym_a:
      assert property ((omode_q == fxq_pkg::fxq_clamp_symmetric && novf_w && dsign_q) |->
                       y_w == {1'b1, {(W-2){1'b0}}, 1'b1})
      else $error("symmetric clamp did not give minus max");

   wrap_sign_a:
      assert property ((omode_q == fxq_pkg::fxq_modular_wrap && dsign_q && nsat_q != 5'h00
                        && (povf_w || novf_w)) |-> y_w[W-1] == q_w[XW-1])
      else $error("wrap with saturated bits lost the sign");

   pass_through_a:
      assert property ((op_q == fxq_pkg::fxq_op_pass && clamp_frac(fa_q) == clamp_frac(fd_q)
                        && asign_q == dsign_q) |-> y_w == opa_q)
      else $error("same-format pass changed the value");

   half_away_a:
      assert property ((qmode_q == fxq_pkg::fxq_round_half_away && q_tie) |-> q_inc == !x_w[XW-1])
      else $error("half away tie went the wrong way");

   clamp_high_a:
      assert property ((omode_q == fxq_pkg::fxq_clamp_to_limits && povf_w) |->
                       y_w == (dsign_q ? {1'b0, {(W-1){1'b1}}} : {W{1'b1}}))
      else $error("positive clamp gave wrong limit");

   plain_wrap_a:
      assert property ((omode_q == fxq_pkg::fxq_modular_wrap && nsat_q == 5'h00) |-> y_w == q_w[W-1:0])
      else $error("plain wrap changed the kept low bits");

endmodule

// [logic/fxq_ovf.sv]
// Overflow stage that fits the quantized value into the destination width.
`timescale 1ns/1ns
module fxq_ovf #(
   parameter int W = 16,
   parameter int XW = 34
) (
   // Quantized value and overflow configuration
   input wire logic [XW-1:0] q,
   input wire fxq_pkg::fxq_omode_e omode,
   input wire logic [4:0] nsat,
   input wire logic dsign,
   // Stored value and range flags
   output logic [W-1:0] y,
   output logic pos_ovf,
   output logic neg_ovf
);

   logic [W-1:0] maxv;
   logic [W-1:0] minv;
   logic [W-1:0] symv;
   logic [W-1:0] nmask;
   logic [W-1:0] wrapv;
   logic [W-1:0] smv;
   logic [4:0] nc;
   logic ovf;

   // Range check on the full quantized value, then the mode picks the stored pattern.
   always_comb begin
      if (dsign) begin
         pos_ovf = ~q[XW-1] & (|q[XW-2:W-1]);
         neg_ovf = q[XW-1] & ~(&q[XW-2:W-1]);
         maxv = {1'b0, {(W-1){1'b1}}};
         minv = {1'b1, {(W-1){1'b0}}};
         symv = {1'b1, {(W-2){1'b0}}, 1'b1};
      end else begin
         pos_ovf = ~q[XW-1] & (|q[XW-2:W]);
         neg_ovf = q[XW-1];
         maxv = {W{1'b1}};
         minv = {W{1'b0}};
         symv = {W{1'b0}};
      end
      ovf = pos_ovf | neg_ovf;
      nc = (nsat > 5'(W)) ? 5'(W) : nsat;
      nmask = ~({W{1'b1}} >> nc);
      // Plain wrap keeps the low bits only.
      wrapv = q[W-1:0];
      if (ovf && nc != 5'h00) begin
         wrapv = wrapv | nmask;
         if (dsign) begin
            wrapv[W-1] = q[XW-1];
         end
      end
      // In range, the lowest dropped bit equals the top kept bit, so this path is the identity there.
      smv = {q[W], q[W] != q[W-1] ? ~q[W-2:0] : q[W-2:0]};
      if (ovf && nc != 5'h00) begin
         smv = smv | nmask;
         smv[W-1] = q[XW-1];
      end
      if (!dsign) begin
         smv = wrapv;
      end
      case (omode)
         fxq_pkg::fxq_clamp_to_limits: y = pos_ovf ? maxv : (neg_ovf ? minv : q[W-1:0]);
         fxq_pkg::fxq_clamp_to_zero: y = ovf ? {W{1'b0}} : q[W-1:0];
         fxq_pkg::fxq_clamp_symmetric: y = pos_ovf ? maxv : (neg_ovf ? symv : q[W-1:0]);
         fxq_pkg::fxq_sign_magnitude_wrap: y = smv;
         fxq_pkg::fxq_modular_wrap: y = wrapv;
         default: y = wrapv;
      endcase
   end

endmodule

// [logic/fxq_pkg.sv]
// Shared constants, register map and mode enumerations of the fixed-point quantize and overflow unit.
package fxq_pkg;

   // Register port geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FRAC = 8'h04;
   localparam logic [7:0] ADDR_OPA = 8'h08;
   localparam logic [7:0] ADDR_OPB = 8'h0c;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_RESULT = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // Field widths shared by the format and mode fields.
   localparam int MODE_BITS = 3;
   localparam int FRAC_BITS = 5;
   localparam int OP_BITS = 2;

   // Control register field positions.
   localparam int QMODE_LSB = 0;
   localparam int OMODE_LSB = 3;
   localparam int NSAT_LSB = 6;
   localparam int DSIGN_BIT = 11;
   localparam int ASIGN_BIT = 12;
   localparam int BSIGN_BIT = 13;
   localparam int OP_LSB = 14;

   // Format register field positions, each a count of fraction bits.
   localparam int FA_LSB = 0;
   localparam int FB_LSB = 8;
   localparam int FD_LSB = 16;

   // Status register bit positions.
   localparam int DONE_BIT = 0;
   localparam int POVF_BIT = 1;
   localparam int NOVF_BIT = 2;
   localparam int INEXACT_BIT = 3;

   // Quantization modes for surplus low-order bits.
   typedef enum logic [2:0] {
      fxq_truncate_floor,
      fxq_truncate_toward_zero,
      fxq_round_half_up,
      fxq_round_half_toward_zero,
      fxq_round_half_down,
      fxq_round_half_away,
      fxq_round_half_even
   } fxq_qmode_e;

   // Overflow modes for surplus high-order bits.
   typedef enum logic [2:0] {
      fxq_modular_wrap,
      fxq_sign_magnitude_wrap,
      fxq_clamp_to_limits,
      fxq_clamp_to_zero,
      fxq_clamp_symmetric
   } fxq_omode_e;

   // Operations on the two source operands.
   typedef enum logic [1:0] {
      fxq_op_add,
      fxq_op_sub,
      fxq_op_pass
   } fxq_op_e;

   // Reset values of the configuration.
   localparam fxq_qmode_e QMODE_RESET = fxq_truncate_floor;
   localparam fxq_omode_e OMODE_RESET = fxq_modular_wrap;
   localparam logic [4:0] NSAT_RESET = 5'h00;
   localparam logic [4:0] FRAC_RESET = 5'h00;
   localparam fxq_op_e OP_RESET = fxq_op_pass;

endpackage

// [logic/fxq_quant.sv]
// Quantizer that removes surplus low-order bits of the aligned value.
`timescale 1ns/1ns
module fxq_quant #(
   parameter int W = 16,
   parameter int XW = 34
) (
   // Aligned value and count of low bits to drop
   input wire logic [XW-1:0] x,
   input wire logic [4:0] r,
   input wire fxq_pkg::fxq_qmode_e qmode,
   // Quantized value in destination units and flags
   output logic [XW-1:0] q,
   output logic inc,
   output logic tie,
   output logic inexact
);

   logic [XW-1:0] mask;
   logic [XW-1:0] t;
   logic half;
   logic sticky;
   logic neg;

   // Floor shift, then one increment chosen by the mode; the shift alone is the floor, so every mode is a +0/+1.
   always_comb begin
      mask = ~({XW{1'b1}} << r);
      t = XW'($signed(x) >>> r);
      half = (r != 5'h00) ? x[r - 5'h01] : 1'b0;
      sticky = |(x & (mask >> 1));
      tie = half & ~sticky;
      inexact = |(x & mask);
      neg = x[XW-1];
      case (qmode)
         fxq_pkg::fxq_round_half_up: inc = half;
         fxq_pkg::fxq_round_half_toward_zero: inc = half & (sticky | neg);
         fxq_pkg::fxq_round_half_down: inc = half & sticky;
         fxq_pkg::fxq_round_half_away: inc = half & (sticky | ~neg);
         fxq_pkg::fxq_round_half_even: inc = half & (sticky | t[0]);
         fxq_pkg::fxq_truncate_toward_zero: inc = neg & inexact;
         fxq_pkg::fxq_truncate_floor: inc = 1'b0;
         default: inc = 1'b0;
      endcase
      q = t + {{(XW-1){1'b0}}, inc};
   end

endmodule

// [sim/fxq_core_tb_top.sv]
// Self-checking bench for the fixed-point convert unit, driven through its register port.
`timescale 1ns/1ns
module fxq_core_tb_top;
   localparam int W = 8;
   logic clk;
   logic nrst;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic [W-1:0] result;
   logic done;
   logic rd_q = 1'b0;
   logic [31:0] seed = 32'h4f08d120;
   logic [31:0] exp_q[$];
   string nm_q[$];
   int fails = 0;
   int cmp_count = 0;

   fxq_core #(.W(W)) fxq_core_inst (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .result(result), .done(done)
   );

   // The clock runs at 20 MHz.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic close_out();
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Operand aligned to W fraction bits; fraction counts above W behave as W.
   function automatic longint fit(input logic [31:0] v, input bit s, input int f);
      longint x;
      x = s ? longint'($signed(v[W-1:0])) : longint'(v[W-1:0]);
      return x <<< (W - f);
   endfunction

   // Reference model: exact op, then quantize, then overflow on the rounded value.
   function automatic void model(input logic [31:0] c, fr, a, b, output logic [31:0] y, st);
      longint x, fl, rm, hf, q, mx, mn;
      int fa, fb, fd, r, n;
      bit up, ds, po, ng;
      fa = fr[4:0] > W ? W : int'(fr[4:0]);
      fb = fr[12:8] > W ? W : int'(fr[12:8]);
      fd = fr[20:16] > W ? W : int'(fr[20:16]);
      n = c[10:6] > W ? W : int'(c[10:6]);
      x = fit(a, c[12], fa);
      if (c[15:14] == 2'h0) x = x + fit(b, c[13], fb);
      else if (c[15:14] == 2'h1) x = x - fit(b, c[13], fb);
      r = W - fd;
      fl = x >>> r;
      rm = x - (fl <<< r);
      hf = (r == 0) ? 0 : (longint'(1) <<< (r - 1));
      case (c[2:0])
         3'h1: up = x < 0 && rm != 0;
         3'h2: up = r > 0 && rm >= hf;
         3'h3: up = rm > hf || (r > 0 && rm == hf && x < 0);
         3'h4: up = rm > hf;
         3'h5: up = rm > hf || (r > 0 && rm == hf && x >= 0);
         3'h6: up = rm > hf || (r > 0 && rm == hf && fl[0]);
         default: up = 1'b0;
      endcase
      q = fl + up;
      ds = c[11];
      mx = ds ? (longint'(1) <<< (W - 1)) - 1 : (longint'(1) <<< W) - 1;
      mn = ds ? -(longint'(1) <<< (W - 1)) : 0;
      po = q > mx;
      ng = q < mn;
      y = '0;
      y[W-1:0] = q[W-1:0];
      case (c[5:3])
         3'h2: if (po) y[W-1:0] = mx[W-1:0]; else if (ng) y[W-1:0] = mn[W-1:0];
         3'h3: if (po || ng) y = '0;
         3'h4: if (po) y[W-1:0] = mx[W-1:0]; else if (ng) y[W-1:0] = ds ? -mx[W-1:0] : '0;
         default: begin
            if (c[5:3] == 3'h1 && ds) begin
               y[W-1] = q[W];
               if (q[W] != q[W-1]) y[W-2:0] = ~q[W-2:0];
            end
            if (n > 0 && (po || ng)) begin
               for (int i = W - n; i < W; i++) y[i] = 1'b1;
               if (ds) y[W-1] = q < 0;
            end
         end
      endcase
      st = {28'h0, rm != 0, ng, po, 1'b1};
   endfunction

   // Each task sets both strobes after the address, so back-to-back cycles never assign one twice.
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      exp_q.push_back(e);
      nm_q.push_back(nm);
      @(posedge clk);
   endtask

   task automatic idle();
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic convert(input logic [31:0] c, fr, a, b);
      logic [31:0] y, st;
      model(c, fr, a, b, y, st);
      wr_reg(fxq_pkg::ADDR_CTRL, c);
      wr_reg(fxq_pkg::ADDR_FRAC, fr);
      wr_reg(fxq_pkg::ADDR_OPA, a);
      wr_reg(fxq_pkg::ADDR_OPB, b);
      wr_reg(fxq_pkg::ADDR_CMD, lfsr(a));
      idle();
      rd_reg(fxq_pkg::ADDR_RESULT, y, "result reg");
      chk("result port", y, {{(32-W){1'b0}}, result});
      chk("done port", 32'h1, {31'h0, done});
      rd_reg(fxq_pkg::ADDR_STATUS, st, "status");
      rd_reg(fxq_pkg::ADDR_STATUS, st & 32'hfffffffe, "status again");
   endtask

   // Read data stand only in the cycle after the read strobe; the oldest note is compared.
   always @(posedge clk) begin
      if (rd_q && exp_q.size() > 0) begin
         chk(nm_q.pop_front(), exp_q.pop_front(), rdata);
      end
      rd_q <= rd;
   end

   // Watchdog sized well above the few thousand cycles the sequence needs.
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      close_out();
   end

   initial begin
      logic [31:0] c, fr, a, b;
      logic [7:0] vals [6];
      vals = '{8'h0a, 8'hf6, 8'h0b, 8'hf5, 8'h0e, 8'hf2};
      nrst = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      // Reset values, read-only places, the command word and an unmapped address.
      c = (32'(fxq_pkg::OP_RESET) << fxq_pkg::OP_LSB) | (32'h7 << fxq_pkg::DSIGN_BIT);
      rd_reg(fxq_pkg::ADDR_CTRL, c, "ctrl reset");
      rd_reg(fxq_pkg::ADDR_FRAC, 32'h0, "frac reset");
      wr_reg(fxq_pkg::ADDR_RESULT, 32'h5a);
      wr_reg(fxq_pkg::ADDR_STATUS, 32'hf);
      rd_reg(fxq_pkg::ADDR_RESULT, 32'h0, "result ro");
      rd_reg(fxq_pkg::ADDR_STATUS, 32'h0, "status ro");
      rd_reg(fxq_pkg::ADDR_CMD, 32'h0, "cmd read");
      rd_reg(8'h1c, 32'h0, "unmapped");
      // Default modes on a tie, then every quantization code on ties and near-ties.
      convert(c, 32'h00010003, 32'h0a, 32'h0);
      for (int qm = 0; qm < 8; qm++) begin
         foreach (vals[i]) begin
            convert(c | qm, 32'h00010003, {24'h0, vals[i]}, 32'h0);
         end
      end
      // Every overflow code, with and without saturated bits, both destination signs.
      for (int om = 0; om < 8; om++) begin
         for (int ns = 0; ns < 6; ns += 3) begin
            for (int ds = 0; ds < 2; ds++) begin
               for (int k = 0; k < 6; k++) begin
                  seed = lfsr(seed);
                  c = (32'(om) << 3) | (32'(ns) << 6) | (32'(ds) << 11);
                  c = (k < 2) ? (c | 32'h3000) : (c | (seed & 32'h0000f007));
                  seed = lfsr(seed);
                  fr = (k < 2) ? 32'h0 : (seed & 32'h000f0f0f);
                  seed = lfsr(seed);
                  a = (k == 0) ? 32'h7f : (k == 1) ? 32'h80 : seed;
                  seed = lfsr(seed);
                  b = (k == 0) ? 32'h7f : (k == 1) ? 32'h80 : seed;
                  convert(c, fr, a, b);
               end
            end
         end
      end
      idle();
      idle();
      close_out();
   end
endmodule
